// >>> core_pkg.sv
// Constants, types and state encodings for the CPU status, stack and interrupt core.
// Assumes a single CPU clock and one asynchronous active-low reset.
package core_pkg;

  // ****************************************
  // I/O offsets and status fields
  // ****************************************
  localparam logic [5:0] io_stack_ptr_low = 6'h3d;
  localparam logic [5:0] io_stack_ptr_high = 6'h3e;
  localparam logic [5:0] io_status_flags = 6'h3f;
  localparam logic [5:0] io_core_control_reg = 6'h35;
  localparam logic [5:0] io_irq_flags = 6'h1c;
  localparam logic [5:0] io_irq_enables = 6'h1d;
  localparam int bit_global_enable = 7;
  localparam int bit_bit_copy = 6;
  localparam int bit_half_carry = 5;
  localparam int bit_sign = 4;
  localparam int bit_overflow = 3;
  localparam int bit_negative = 2;
  localparam int bit_zero = 1;
  localparam int bit_carry = 0;
  localparam int bit_vector_base_select = 1;
  localparam logic [7:0] status_flags_reset = 8'h00;
  localparam logic [15:0] sram_last_addr = 16'h08ff;
  localparam logic [15:0] boot_base_addr = 16'h3c00;
  localparam logic [15:0] vector_step = 16'h0002;
  localparam logic [4:0] pointer_first = 5'h1a;
  localparam int irq_entry_cycles = 4;

  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_push_lo = 3'b001,
    st_push_hi = 3'b011,
    st_vector = 3'b010,
    st_settle = 3'b110
  } irq_state_t;

  typedef enum logic [2:0] {
    sp_hold = 3'h0,
    sp_push = 3'h1,
    sp_pop = 3'h2,
    sp_call = 3'h3,
    sp_ret = 3'h4,
    sp_return_from_irq = 3'h5
  } stack_op_t;

  typedef enum logic [1:0] {
    ptr_plain = 2'h0,
    ptr_post_inc = 2'h1,
    ptr_pre_dec = 2'h2,
    ptr_disp = 2'h3
  } ptr_mode_t;

endpackage

// >>> irq_arbiter.sv
// Fixed-priority pick among pending, enabled interrupt lines.
// Assumes requests already gated by enables; lowest index ranks highest.
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter #(
  parameter int n_irq = 8
) (
  input wire logic [n_irq-1:0] req,
  output logic any,
  output logic [$clog2(n_irq)-1:0] index
);
  always_comb
  begin
    any = 1'b0;
    index = '0;
    for (int i = n_irq - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any = 1'b1;
        index = i[$clog2(n_irq)-1:0];
      end
    end
  end
endmodule // irq_arbiter
`default_nettype wire

// >>> cpu_status_stack_interrupt_core.sv
// Status flags, register file, pointers, stack pointer and interrupt sequencing.
// Assumes decoder/ALU on the same undivided clock, and synchronous interrupt sources.
`timescale 1ns/1ps
`default_nettype none
module cpu_status_stack_interrupt_core
  import core_pkg::*;
#(
  parameter int n_irq = 8,
  parameter logic [n_irq-1:0] level_mask = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  // Register file ports
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  input wire logic wb_en,
  input wire logic wb_wide,
  input wire logic [4:0] wb_addr,
  input wire logic [15:0] wb_data,
  // Status flags from ALU
  input wire logic [7:0] flag_update_mask,
  input wire logic [7:0] flag_values,
  input wire logic global_set,
  input wire logic global_clear,
  // Pointer ops (0 X, 1 Y, 2 Z)
  input wire logic ptr_en,
  input wire logic [1:0] ptr_sel,
  input wire logic [1:0] ptr_mode,
  input wire logic [5:0] ptr_disp_val,
  // Data-space access to registers
  input wire logic [15:0] ds_addr,
  input wire logic ds_wr,
  input wire logic [7:0] ds_wdata,
  // I/O register access
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  // Stack
  input wire logic [2:0] stack_op,
  input wire logic instr_done,
  // Interrupt sources
  input wire logic [n_irq-1:0] irq_event,
  input wire logic [n_irq-1:0] irq_level,
  output logic [7:0] rd_data_a,
  output logic [7:0] rd_data_b,
  output logic [15:0] rd_data_wide,
  output logic [7:0] ds_rdata,
  output logic [15:0] ptr_addr,
  output logic [7:0] io_rdata,
  output logic [7:0] status_flags_out,
  output logic [15:0] stack_ptr,
  output logic irq_take,
  output logic [15:0] irq_vector,
  output logic irq_busy
);

  // Enables and flags are one 8-bit I/O register each
  if (n_irq < 2 || n_irq > 8)
  begin : g_bad_n_irq
    $error("n_irq out of range");
  end

  localparam int iw = $clog2(n_irq);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] regs [32];
  logic [7:0] status_flags;
  logic [15:0] sp;
  logic [7:0] core_control_reg;
  logic [n_irq-1:0] irq_flags;
  logic [n_irq-1:0] irq_enables;
  irq_state_t state;
  logic after_return;

  logic [n_irq-1:0] pending;
  logic [n_irq-1:0] ready;
  logic any_ready;
  logic [iw-1:0] pick;
  logic can_take;
  logic [15:0] sp_next;
  logic [15:0] ptr_base;
  logic [15:0] next_ptr;
  logic [15:0] ptr_eff;
  logic [4:0] ptr_lo_idx;
  logic ds_hit;
  logic sp_io_wr;

  // ****************************************
  // Interrupt arbitration
  // ****************************************
  assign pending = (irq_flags & ~level_mask) | (irq_level & level_mask);
  assign ready = pending & irq_enables;
  // Global clear in this cycle blocks the take as well
  assign can_take = status_flags[bit_global_enable] && !global_clear
                    && state == st_run && instr_done && !after_return;

  irq_arbiter #(
    .n_irq(n_irq)
  ) u_arb (
    .req(ready),
    .any(any_ready),
    .index(pick)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= st_run;
      irq_take <= 1'b0;
      irq_busy <= 1'b0;
      irq_vector <= 16'h0000;
    end
    else
    begin
      irq_take <= 1'b0;
      case (state)
        st_run:
        begin
          if (can_take && any_ready)
          begin
            state <= st_push_lo;
            irq_take <= 1'b1;
            irq_busy <= 1'b1;
            // Vector 0 is reset; sources start at vector 1
            irq_vector <= (core_control_reg[bit_vector_base_select] ? boot_base_addr
                          : 16'h0000) + vector_step * (16'(pick) + 16'h0001);
          end
        end
        st_push_lo:
        begin
          state <= st_push_hi;
        end
        st_push_hi:
        begin
          state <= st_vector;
        end
        st_vector:
        begin
          state <= st_settle;
        end
        st_settle:
        begin
          state <= st_run;
          irq_busy <= 1'b0;
        end
        default:
        begin
          state <= st_run;
        end
      endcase
    end
  end

  // One instruction after a return before another entry
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      after_return <= 1'b0;
    end
    else if (stack_op == sp_return_from_irq)
    begin
      after_return <= 1'b1;
    end
    else if (instr_done)
    begin
      after_return <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt flags and enables
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_flags <= '0;
    end
    else
    begin
      for (int i = 0; i < n_irq; i++)
      begin
        if (irq_event[i])
        begin
          irq_flags[i] <= 1'b1;
        end
        else if (io_wr && io_addr == io_irq_flags && i < 8 && io_wdata[i % 8])
        begin
          irq_flags[i] <= 1'b0;
        end
        else if (state == st_run && can_take && any_ready && pick == i[iw-1:0])
        begin
          irq_flags[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_enables <= '0;
      core_control_reg <= 8'h00;
    end
    else if (io_wr && io_addr == io_irq_enables)
    begin
      for (int i = 0; i < n_irq && i < 8; i++)
      begin
        irq_enables[i] <= io_wdata[i];
      end
    end
    else if (io_wr && io_addr == io_core_control_reg)
    begin
      core_control_reg <= io_wdata;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_flags <= status_flags_reset;
    end
    else if (io_wr && io_addr == io_status_flags)
    begin
      // Sign stays N xor V even on a direct write
      status_flags <= {io_wdata[7:5], io_wdata[2] ^ io_wdata[3], io_wdata[3:0]};
      if (global_clear || (state == st_run && can_take && any_ready))
      begin
        status_flags[bit_global_enable] <= 1'b0;
      end
    end
    else
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (flag_update_mask[b] && b != bit_sign)
        begin
          status_flags[b] <= flag_values[b];
        end
      end
      status_flags[bit_sign] <= (flag_update_mask[bit_negative] ? flag_values[bit_negative]
                                : status_flags[bit_negative])
                                ^ (flag_update_mask[bit_overflow] ? flag_values[bit_overflow]
                                : status_flags[bit_overflow]);
      // Entry and clear win over set; return and set raise it, a flag update of bit 7 loads flag_values[7]
      if (global_clear || (state == st_run && can_take && any_ready))
      begin
        status_flags[bit_global_enable] <= 1'b0;
      end
      else if (global_set || stack_op == sp_return_from_irq)
      begin
        status_flags[bit_global_enable] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Stack pointer
  // ****************************************
  always_comb
  begin
    case (stack_op_t'(stack_op))
      sp_push: sp_next = sp - 16'h0001;
      sp_pop: sp_next = sp + 16'h0001;
      sp_call: sp_next = sp - 16'h0002;
      sp_ret, sp_return_from_irq: sp_next = sp + 16'h0002;
      default: sp_next = sp;
    endcase
  end

  assign sp_io_wr = io_wr && (io_addr == io_stack_ptr_low || io_addr == io_stack_ptr_high);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sp <= sram_last_addr;
    end
    else if (state == st_push_hi)
    begin
      sp <= sp - 16'h0002;
    end
    else if (sp_io_wr)
    begin
      if (io_addr == io_stack_ptr_low)
      begin
        sp[7:0] <= io_wdata;
      end
      else
      begin
        sp[15:8] <= io_wdata;
      end
    end
    else
    begin
      sp <= sp_next;
    end
  end

  // ****************************************
  // Register file and pointers
  // ****************************************
  assign ptr_lo_idx = pointer_first + {2'b00, ptr_sel, 1'b0};
  assign ptr_base = {regs[ptr_lo_idx + 5'h01], regs[ptr_lo_idx]};
  assign ds_hit = ds_addr < 16'h0020;

  always_comb
  begin
    next_ptr = ptr_base;
    ptr_eff = ptr_base;
    case (ptr_mode_t'(ptr_mode))
      ptr_post_inc: next_ptr = ptr_base + 16'h0001;
      ptr_pre_dec:
      begin
        next_ptr = ptr_base - 16'h0001;
        ptr_eff = next_ptr;
      end
      ptr_disp: ptr_eff = ptr_base + {10'h000, ptr_disp_val};
      default: next_ptr = ptr_base;
    endcase
  end

  // Writeback, data-space write and pointer step; later wins on conflict
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int r = 0; r < 32; r++)
      begin
        regs[r] <= 8'h00;
      end
    end
    else
    begin
      if (wb_en)
      begin
        regs[wb_addr] <= wb_data[7:0];
        if (wb_wide)
        begin
          regs[wb_addr + 5'h01] <= wb_data[15:8];
        end
      end
      if (ds_wr && ds_hit)
      begin
        regs[ds_addr[4:0]] <= ds_wdata;
      end
      if (ptr_en && ptr_sel != 2'h3 && ptr_mode != ptr_disp && ptr_mode != ptr_plain)
      begin
        regs[ptr_lo_idx] <= next_ptr[7:0];
        regs[ptr_lo_idx + 5'h01] <= next_ptr[15:8];
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_a <= 8'h00;
      rd_data_b <= 8'h00;
      rd_data_wide <= 16'h0000;
      ds_rdata <= 8'h00;
      ptr_addr <= 16'h0000;
      io_rdata <= 8'h00;
      status_flags_out <= status_flags_reset;
      stack_ptr <= sram_last_addr;
    end
    else
    begin
      rd_data_a <= regs[rd_addr_a];
      rd_data_b <= regs[rd_addr_b];
      rd_data_wide <= {regs[rd_addr_a + 5'h01], regs[rd_addr_a]};
      ds_rdata <= ds_hit ? regs[ds_addr[4:0]] : 8'h00;
      ptr_addr <= ptr_eff;
      status_flags_out <= status_flags;
      stack_ptr <= sp;
      if (io_rd)
      begin
        if (io_addr == io_stack_ptr_low)
        begin
          io_rdata <= sp[7:0];
        end
        else if (io_addr == io_stack_ptr_high)
        begin
          io_rdata <= sp[15:8];
        end
        else if (io_addr == io_status_flags)
        begin
          io_rdata <= status_flags;
        end
        else if (io_addr == io_core_control_reg)
        begin
          io_rdata <= core_control_reg;
        end
        else if (io_addr == io_irq_flags)
        begin
          io_rdata <= 8'(irq_flags);
        end
        else if (io_addr == io_irq_enables)
        begin
          io_rdata <= 8'(irq_enables);
        end
        else
        begin
          io_rdata <= 8'h00;
        end
      end
    end
  end

  // everything here runs on clk with no divider

endmodule // cpu_status_stack_interrupt_core
`default_nettype wire

// >>> core_assertions.sv
// Port checks for the status, stack and interrupt core.
// Bound to the core; one clock domain, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module core_assertions
  import core_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] flag_update_mask,
  input wire logic [7:0] flag_values,
  input wire logic global_clear,
  input wire logic io_wr,
  input wire logic [2:0] stack_op,
  input wire logic instr_done,
  input wire logic [7:0] status_flags_out,
  input wire logic [15:0] stack_ptr,
  input wire logic irq_take,
  input wire logic irq_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic quiet;
  assign quiet = !io_wr && !irq_busy && !irq_take;
  // ****
  // Flags, stack steps, interrupt entry
  // ****
  sequence entry_s;
    irq_busy [*4] ##1 !irq_busy;
  endsequence
  // Stack output lags the pointer by one register stage
  sequence ptr_drop_s;
    ##3 stack_ptr == $past(stack_ptr, 3) - 16'h0002;
  endsequence
  sign_flag_a: assert property (status_flags_out[4] ==
    (status_flags_out[2] ^ status_flags_out[3])) else $error("sign flag wrong");
  flag_load_a: assert property (|flag_update_mask[3:0] && !io_wr |-> ##2
    ((status_flags_out[3:0] ^ $past(flag_values[3:0], 2))
    & $past(flag_update_mask[3:0], 2)) == 4'h0)
    else $error("flag load wrong");
  push_step_a: assert property (stack_op == sp_push && quiet |=> ##1
    stack_ptr == $past(stack_ptr) - 16'h0001) else $error("push step wrong");
  pop_step_a: assert property (stack_op == sp_pop && quiet |=> ##1
    stack_ptr == $past(stack_ptr) + 16'h0001) else $error("pop step wrong");
  call_step_a: assert property (stack_op == sp_call && quiet |=> ##1
    stack_ptr == $past(stack_ptr) - 16'h0002) else $error("call step wrong");
  return_step_a: assert property ((stack_op == sp_ret || stack_op == sp_return_from_irq) && quiet |=> ##1
    stack_ptr == $past(stack_ptr) + 16'h0002) else $error("return step wrong");
  return_from_irq_enable_a: assert property (stack_op == sp_return_from_irq && quiet && !global_clear |=> ##1
    status_flags_out[7]) else $error("return did not enable");
  take_gate_a: assert property (irq_take |-> status_flags_out[7] &&
    $past(instr_done) && !$past(global_clear)) else $error("take not allowed");
  take_entry_a: assert property ($rose(irq_take) |->
    entry_s and (##1 !status_flags_out[7])) else $error("entry sequence wrong");
  entry_push_a: assert property ($rose(irq_take) |-> ptr_drop_s)
    else $error("entry push wrong");
  take_pulse_a: assert property (irq_take |=> !irq_take [*3])
    else $error("take not a pulse");
endmodule // core_assertions
bind cpu_status_stack_interrupt_core core_assertions u_chk (.clk, .arst_n, .flag_update_mask,
  .flag_values, .global_clear, .io_wr, .stack_op, .instr_done, .status_flags_out, .stack_ptr,
  .irq_take, .irq_busy);
`default_nettype wire

// >>> irq_source_model.sv
// Peripheral request model: flag events as one-cycle pulses, level conditions.
// Commands come from the bench; outputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module irq_source_model #(
  parameter int n = 8
) (
  input wire logic clk,
  input wire logic [n-1:0] fire,
  input wire logic [n-1:0] cond,
  output logic [n-1:0] irq_event,
  output logic [n-1:0] irq_level
);
  logic [n-1:0] last;
  initial
  begin
    irq_event = '0;
    irq_level = '0;
    last = '0;
  end
  always @(negedge clk)
  begin
    irq_event <= fire & ~last;
    last <= fire;
    irq_level <= cond;
  end
endmodule // irq_source_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the status, stack and interrupt core.
// Inputs change at the falling edge; requests come from the source model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import core_pkg::*;
  // ****
  // Stimulus and checking
  // ****
  logic clk = '0, arst_n = '0, wb_en = '0, wb_wide = '0, global_set = '0, global_clear = '0;
  logic ptr_en = '0, ds_wr = '0, io_wr = '0, io_rd = '0, instr_done = '0, irq_take, irq_busy;
  logic [4:0] rd_addr_a = '0, rd_addr_b = '0, wb_addr = '0;
  logic [15:0] wb_data = '0, ds_addr = '0, sp, n_take = '0, last_vec = '0;
  logic [7:0] flag_update_mask = '0, flag_values = '0, ds_wdata = '0, io_wdata = '0;
  logic [7:0] fire = '0, cond = '0, irq_event, irq_level, rd_data_a, rd_data_b;
  logic [7:0] ds_rdata, io_rdata, status_flags_out;
  logic [1:0] ptr_sel = '0, ptr_mode = '0;
  logic [5:0] ptr_disp_val = '0, io_addr = '0;
  logic [2:0] stack_op = '0, op;
  logic [15:0] rd_data_wide, ptr_addr, stack_ptr, irq_vector;
  logic [31:0] seed = 32'h5b64, r;
  logic [3:0] fl = '0;
  int err_count = 0, num_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  cpu_status_stack_interrupt_core #(.n_irq(8), .level_mask(8'h80)) dut (.clk, .arst_n,
    .rd_addr_a, .rd_addr_b, .wb_en, .wb_wide, .wb_addr, .wb_data, .flag_update_mask,
    .flag_values, .global_set, .global_clear, .ptr_en, .ptr_sel, .ptr_mode, .ptr_disp_val,
    .ds_addr, .ds_wr, .ds_wdata, .io_addr, .io_wr, .io_rd, .io_wdata, .stack_op, .instr_done,
    .irq_event, .irq_level, .rd_data_a, .rd_data_b, .rd_data_wide, .ds_rdata, .ptr_addr,
    .io_rdata, .status_flags_out, .stack_ptr, .irq_take, .irq_vector, .irq_busy);
  irq_source_model #(.n(8)) src (.clk, .fire, .cond, .irq_event, .irq_level);
  always @(negedge clk)
    if (irq_take === 1'h1)
    begin
      n_take <= n_take + 16'h0001;
      last_vec <= irq_vector;
    end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] vec(input int i, input logic b);
    return (b ? boot_base_addr : 16'h0000) + vector_step * 16'(i + 1);
  endfunction
  function automatic logic [15:0] sp_next(input logic [2:0] o, input logic [15:0] s);
    case (o)
      sp_push: return s - 16'h0001;
      sp_pop: return s + 16'h0001;
      sp_call: return s - 16'h0002;
      default: return s + 16'h0002;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic io(input logic [5:0] a, input logic [7:0] d, input logic w);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    tick(1);
    io_wr = 1'h0;
    io_rd = 1'h0;
    tick(2);
  endtask
  task automatic sop(input logic [2:0] o);
    stack_op = o;
    tick(1);
    stack_op = sp_hold;
    tick(2);
  endtask
  task automatic wb(input logic [4:0] a, input logic [15:0] d, input logic w);
    wb_addr = a;
    wb_data = d;
    wb_wide = w;
    wb_en = 1'h1;
    tick(1);
    wb_en = 1'h0;
    tick(2);
  endtask
  task automatic ptr(input logic [1:0] s, input logic [1:0] m, input logic [15:0] e);
    ptr_sel = s;
    ptr_mode = m;
    ptr_en = 1'h1;
    tick(1);
    chk(ptr_addr, e);
    ptr_en = 1'h0;
    tick(2);
  endtask
  task automatic gl(input logic s);
    global_set = s;
    global_clear = !s;
    tick(1);
    global_set = 1'h0;
    global_clear = 1'h0;
    tick(1);
  endtask
  task automatic src_fire(input logic [7:0] b);
    fire = b;
    tick(2);
    fire = '0;
    tick(3);
  endtask
  task automatic done();
    instr_done = 1'h1;
    tick(1);
    instr_done = 1'h0;
    tick(8);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    tick(6);
    arst_n = 1'h1;
    chk(stack_ptr, sram_last_addr);
    r = xs();
    sp = {8'h04, r[7:0]};
    io(io_stack_ptr_low, sp[7:0], 1'h1);
    io(io_stack_ptr_high, sp[15:8], 1'h1);
    io(io_stack_ptr_high, 8'h00, 1'h0);
    chk({8'h00, io_rdata}, {8'h00, sp[15:8]});
    io(io_stack_ptr_low, 8'h00, 1'h0);
    chk({8'h00, io_rdata}, {8'h00, sp[7:0]});
    io(6'h3b, 8'h00, 1'h0);
    chk({8'h00, io_rdata}, 16'h0000);
    repeat (12)
    begin
      r = xs();
      op = {1'h0, r[1:0]} + 3'h1;
      sp = sp_next(op, sp);
      sop(op);
      chk(stack_ptr, sp);
    end
    repeat (8)
    begin
      r = xs();
      fl = (fl & ~r[11:8]) | (r[3:0] & r[11:8]);
      flag_values = r[7:0];
      flag_update_mask = {4'h0, r[11:8]};
      tick(1);
      flag_update_mask = 8'h00;
      tick(1);
      chk({11'h000, status_flags_out[4:0]}, {11'h000, fl[2] ^ fl[3], fl});
    end
    repeat (4)
    begin
      r = xs();
      wb({r[4:1], 1'h0}, r[31:16], 1'h1);
      wb({r[4:1], 1'h1}, {8'h00, r[15:8]}, 1'h0);
      rd_addr_a = {r[4:1], 1'h0};
      ds_addr = {11'h000, r[4:1], 1'h1};
      ds_wdata = r[7:0];
      ds_wr = 1'h1;
      tick(1);
      ds_wr = 1'h0;
      rd_addr_b = {r[4:1], 1'h1};
      tick(2);
      chk(rd_data_wide, {r[7:0], r[23:16]});
      chk({8'h00, rd_data_a}, {8'h00, r[23:16]});
      chk({8'h00, rd_data_b}, {8'h00, r[7:0]});
      chk({8'h00, ds_rdata}, {8'h00, r[7:0]});
    end
    r = xs();
    wb(pointer_first, r[15:0], 1'h1);
    ptr(2'h0, ptr_post_inc, r[15:0]);
    ptr(2'h0, ptr_plain, r[15:0] + 16'h0001);
    ptr(2'h0, ptr_pre_dec, r[15:0]);
    wb(5'h1c, r[31:16], 1'h1);
    ptr_disp_val = 6'h3f;
    ptr(2'h1, ptr_disp, r[31:16] + 16'h003f);
    io(io_irq_enables, 8'h24, 1'h1);
    src_fire(8'h24);
    done();
    chk(n_take, 16'h0000);
    gl(1'h1);
    sp = stack_ptr;
    done();
    chk(last_vec, vec(2, 1'h0));
    chk(stack_ptr, sp - 16'h0002);
    chk({15'h0000, status_flags_out[7]}, 16'h0000);
    io(io_irq_flags, 8'h00, 1'h0);
    chk({8'h00, io_rdata}, 16'h0020);
    sop(sp_return_from_irq);
    chk({15'h0000, status_flags_out[7]}, 16'h0001);
    done();
    chk(n_take, 16'h0001);
    done();
    chk(last_vec, vec(5, 1'h0));
    sop(sp_return_from_irq);
    done();
    src_fire(8'h04);
    global_clear = 1'h1;
    instr_done = 1'h1;
    tick(1);
    global_clear = 1'h0;
    instr_done = 1'h0;
    tick(8);
    chk(n_take, 16'h0002);
    io(io_irq_flags, 8'h04, 1'h1);
    io(io_irq_flags, 8'h00, 1'h0);
    chk({8'h00, io_rdata}, 16'h0000);
    src_fire(8'h08);
    gl(1'h1);
    done();
    chk(n_take, 16'h0002);
    io(io_irq_flags, 8'h08, 1'h1);
    io(io_core_control_reg, 8'h02, 1'h1);
    src_fire(8'h20);
    done();
    chk(last_vec, vec(5, 1'h1));
    io(io_core_control_reg, 8'h00, 1'h1);
    sop(sp_return_from_irq);
    done();
    gl(1'h0);
    io(io_irq_enables, 8'h80, 1'h1);
    cond = 8'h80;
    tick(3);
    cond = 8'h00;
    tick(2);
    gl(1'h1);
    done();
    chk(n_take, 16'h0003);
    cond = 8'h80;
    tick(2);
    done();
    chk(last_vec, vec(7, 1'h0));
    cond = 8'h00;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
